// ===== verilog/rtc_conv_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Trigger source chosen by 3-bit field
// - Pass every Nth trigger; 0,1 pass all
// - Predivider sets capacitance to temperature rate ratio
// - Predivider also divides slow oscillator triggers
// - Averaging depth none, 4, 8, 16 samples
// - Discard 2 or 8 warm-up measurements
// - Reference bit picks port a or internal
// - Each external port measured only when enabled
// - Internal sensor and resistor gated by enables
// - Measurement cycle lasts 140 or 280 us
// - Slow oscillator divided by 1, 4, 8, 16
// - Five-bit capacitance reference code output
module rtc_conv_ctrl
  import rtc_pkg::*;
#(
  parameter int DIV_W    = 22,
  parameter int CYC_SHORT = RTC_CYC_SHORT_CLKS,
  parameter int CYC_LONG  = RTC_CYC_LONG_CLKS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic        osc_tick_i,
  input  wire logic        pin_trig_i,
  input  wire logic        cap_trig_i,
  input  wire logic        cap_run_end_i,
  output logic             conv_clk_o,
  output logic             meas_start_o,
  output logic             meas_keep_o,
  output logic             avg_done_o,
  output logic      [4:0]  port_sel_o,
  output logic             ref_internal_o,
  output logic      [4:0]  cap_ref_code_o
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] trig_q, dlo_q, dmi_q, dhi_q, warm_q, ports_q, cref_q;
  logic       alt_bank_q;

  wire        req    = cyc_i && stb_i && !ack_o && !err_o;
  wire [7:0]  idx    = adr_i[9:2];
  wire        mapped = (idx >= RTC_IDX_TRIG) && (idx <= RTC_IDX_STAT)
                       && (adr_i[31:10] == 22'h00_0000);
  wire        wr     = req && we_i && mapped && sel_i[0];

  function automatic logic hit_w(input logic [7:0] i);
    hit_w = wr && (idx == i);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_q     <= RTC_RST_REG;
      dlo_q      <= RTC_RST_REG;
      dmi_q      <= RTC_RST_REG;
      dhi_q      <= RTC_RST_REG;
      warm_q     <= RTC_RST_REG;
      ports_q    <= RTC_RST_REG;
      cref_q     <= RTC_RST_REG;
      alt_bank_q <= 1'b0;
    end else begin
      if (hit_w(RTC_IDX_TRIG))   trig_q     <= dat_i[7:0];
      if (hit_w(RTC_IDX_DIV_LO)) dlo_q      <= dat_i[7:0];
      if (hit_w(RTC_IDX_DIV_MI)) dmi_q      <= dat_i[7:0];
      if (hit_w(RTC_IDX_DIV_HI)) dhi_q      <= dat_i[7:0];
      if (hit_w(RTC_IDX_WARM))   warm_q     <= dat_i[7:0];
      if (hit_w(RTC_IDX_PORTS))  ports_q    <= dat_i[7:0];
      if (hit_w(RTC_IDX_CREF))   cref_q     <= dat_i[7:0];
      if (hit_w(RTC_IDX_CTRL))   alt_bank_q <= dat_i[0];
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [2:0] src_main  = trig_q[RTC_TRIG_SRC_LSB +: 3];
  wire [2:0] src_alt   = trig_q[RTC_TRIG_ALT_LSB +: 3];
  wire [2:0] src       = alt_bank_q ? src_alt : src_main;
  wire [DIV_W-1:0] ratio = {dhi_q[5:0], dmi_q, dlo_q};
  wire [1:0] avg_sel   = dhi_q[RTC_AVG_LSB +: 2];
  wire       warm_long = warm_q[RTC_WARM_BIT];
  wire       cyc_long  = cref_q[RTC_CYCLE_BIT];
  wire [1:0] clk_div   = cref_q[RTC_CLKDIV_LSB +: 2];

  // ----------------------------------------------------------------
  // Slow oscillator divider for the converter clock
  // ----------------------------------------------------------------
  logic [3:0] odiv_q;
  wire  [3:0] odiv_top = (clk_div == 2'd0) ? 4'h0 :
                         (clk_div == 2'd1) ? 4'h3 :
                         (clk_div == 2'd2) ? 4'h7 : 4'hf;
  wire        odiv_wrap = osc_tick_i && (odiv_q >= odiv_top);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odiv_q     <= 4'h0;
      conv_clk_o <= 1'b0;
    end else begin
      conv_clk_o <= odiv_wrap;
      if (osc_tick_i) odiv_q <= odiv_wrap ? 4'h0 : odiv_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Trigger selection and predivider
  // ----------------------------------------------------------------
  logic pin_q, cap_end_q;
  wire  pin_rise = pin_trig_i && !pin_q;
  wire  end_rise = cap_run_end_i && !cap_end_q;
  wire  trig_evt = (src == RTC_SRC_OSC)   ? osc_tick_i :
                   (src == RTC_SRC_PIN)   ? pin_rise :
                   (src == RTC_SRC_CASYN) ? cap_trig_i :
                   (src == RTC_SRC_CSYN)  ? end_rise : 1'b0;
  logic trig_pass;

  rtc_trig_div #(.W(DIV_W)) u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .event_i (trig_evt),
    .ratio_i (ratio),
    .pass_o  (trig_pass)
  );

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  rtc_state_t st_q, st_d;
  logic [4:0]  mcnt_q;
  logic [31:0] tcnt_q;
  wire  [4:0]  warm_n = warm_long ? RTC_WARM_LONG : RTC_WARM_SHORT;
  wire  [4:0]  meas_n = (avg_sel == 2'd0) ? 5'd1 :
                        (avg_sel == 2'd1) ? 5'd4 :
                        (avg_sel == 2'd2) ? 5'd8 : 5'd16;
  wire  [31:0] cyc_n  = cyc_long ? 32'(CYC_LONG) : 32'(CYC_SHORT);
  wire         cyc_end = (tcnt_q == cyc_n - 32'd1);
  wire         any_port = |port_sel_o;

  always_comb begin
    st_d = st_q;
    case (st_q)
      RTC_IDLE: if (trig_pass && any_port) st_d = RTC_WARM;
      RTC_WARM: if (cyc_end && mcnt_q == warm_n - 5'd1) st_d = RTC_MEAS;
      RTC_MEAS: if (cyc_end && mcnt_q == meas_n - 5'd1) st_d = RTC_DONE;
      RTC_DONE: st_d = RTC_IDLE;
      default:  st_d = RTC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= RTC_IDLE;
      mcnt_q       <= 5'd0;
      tcnt_q       <= 32'd0;
      pin_q        <= 1'b0;
      cap_end_q    <= 1'b0;
      meas_start_o <= 1'b0;
      meas_keep_o  <= 1'b0;
      avg_done_o   <= 1'b0;
    end else begin
      pin_q        <= pin_trig_i;
      cap_end_q    <= cap_run_end_i;
      st_q         <= st_d;
      avg_done_o   <= (st_d == RTC_DONE);
      meas_start_o <= (st_d != st_q && st_d != RTC_DONE
                       && st_d != RTC_IDLE) ||
                      (st_q != RTC_IDLE && st_q != RTC_DONE
                       && cyc_end && st_d == st_q);
      meas_keep_o  <= (st_d == RTC_MEAS);
      if (st_d != st_q) begin
        mcnt_q <= 5'd0;
        tcnt_q <= 32'd0;
      end else if (cyc_end) begin
        mcnt_q <= mcnt_q + 5'd1;
        tcnt_q <= 32'd0;
      end else if (st_q != RTC_IDLE) begin
        tcnt_q <= tcnt_q + 32'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port and reference outputs
  // ----------------------------------------------------------------
  // Sensor port a is the external reference when internal is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_sel_o     <= 5'h00;
      ref_internal_o <= 1'b0;
      cap_ref_code_o <= 5'h00;
    end else begin
      ref_internal_o <= ports_q[6];
      port_sel_o     <= {ports_q[4], ports_q[3], ports_q[2],
                         ports_q[1], ports_q[0]};
      cap_ref_code_o <= cref_q[RTC_CREF_LSB +: 5];
    end
  end

  // ----------------------------------------------------------------
  // Bus answer; unmapped reads and writes give an error, one cycle later
  // ----------------------------------------------------------------
  wire [7:0] rd_byte =
      (idx == RTC_IDX_TRIG)   ? trig_q  :
      (idx == RTC_IDX_DIV_LO) ? dlo_q   :
      (idx == RTC_IDX_DIV_MI) ? dmi_q   :
      (idx == RTC_IDX_DIV_HI) ? dhi_q   :
      (idx == RTC_IDX_WARM)   ? warm_q  :
      (idx == RTC_IDX_PORTS)  ? ports_q :
      (idx == RTC_IDX_CREF)   ? cref_q  :
      (idx == RTC_IDX_CTRL)   ? {7'h00, alt_bank_q} :
      {2'b00, meas_keep_o, avg_done_o, st_q};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
      dat_o <= (req && mapped && !we_i) ? {24'h00_0000, rd_byte}
                                        : 32'h0000_0000;
    end
  end

endmodule

// ===== verilog/rtc_pkg.sv
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (printed offsets are not word multiples: index)
  // ----------------------------------------------------------------
  localparam logic [7:0] RTC_IDX_TRIG   = 8'h1d;
  localparam logic [7:0] RTC_IDX_DIV_LO = 8'h1e;
  localparam logic [7:0] RTC_IDX_DIV_MI = 8'h1f;
  localparam logic [7:0] RTC_IDX_DIV_HI = 8'h20;
  localparam logic [7:0] RTC_IDX_WARM   = 8'h21;
  localparam logic [7:0] RTC_IDX_PORTS  = 8'h22;
  localparam logic [7:0] RTC_IDX_CREF   = 8'h23;
  localparam logic [7:0] RTC_IDX_CTRL   = 8'h24;
  localparam logic [7:0] RTC_IDX_STAT   = 8'h25;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RTC_TRIG_SRC_LSB = 0;
  localparam int RTC_TRIG_ALT_LSB = 3;
  localparam int RTC_START_PIN_LSB = 6;
  localparam int RTC_AVG_LSB      = 6;
  localparam int RTC_WARM_BIT     = 6;
  localparam int RTC_CYCLE_BIT    = 2;
  localparam int RTC_CLKDIV_LSB   = 0;
  localparam int RTC_CREF_LSB     = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RTC_RST_REG = 8'h00;

  // ----------------------------------------------------------------
  // Trigger source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RTC_SRC_OFF   = 3'h0;
  localparam logic [2:0] RTC_SRC_OSC   = 3'h1;
  localparam logic [2:0] RTC_SRC_PIN   = 3'h3;
  localparam logic [2:0] RTC_SRC_CASYN = 3'h5;
  localparam logic [2:0] RTC_SRC_CSYN  = 3'h6;

  // ----------------------------------------------------------------
  // Warm-up counts and cycle times
  // ----------------------------------------------------------------
  localparam logic [4:0] RTC_WARM_SHORT = 5'h02;
  localparam logic [4:0] RTC_WARM_LONG  = 5'h08;
  localparam int RTC_CYCLE_SHORT_US = 140;
  localparam int RTC_CYCLE_LONG_US  = 280;
  localparam int RTC_CLK_MHZ        = 200;
  localparam int RTC_CYC_SHORT_CLKS = RTC_CYCLE_SHORT_US * RTC_CLK_MHZ;
  localparam int RTC_CYC_LONG_CLKS  = RTC_CYCLE_LONG_US * RTC_CLK_MHZ;

  typedef enum logic [3:0] {
    RTC_IDLE  = 4'b0001,
    RTC_WARM  = 4'b0010,
    RTC_MEAS  = 4'b0100,
    RTC_DONE  = 4'b1000
  } rtc_state_t;

endpackage

// ===== verilog/rtc_trig_div.sv
`timescale 1ns/1ps
// Predivider: passes every Nth event, N of 0 or 1 passes all
module rtc_trig_div
  import rtc_pkg::*;
#(
  parameter int W = 22
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         event_i,
  input  wire logic [W-1:0] ratio_i,
  output logic              pass_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         hit;

  // Compare against ratio-1; ratio 0 and 1 both hit at once through the separate ratio_i <= 1 test
  assign hit   = (ratio_i <= W'(1)) || (cnt_q >= ratio_i - W'(1));
  assign cnt_d = hit ? '0 : cnt_q + W'(1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      pass_o <= 1'b0;
    end else begin
      pass_o <= event_i && hit;
      if (event_i) begin
        cnt_q <= cnt_d;
      end
    end
  end

endmodule

// ===== test/rtc_conv_ctrl_asserts.sv
`timescale 1ns/1ps
module rtc_conv_ctrl_asserts
  import rtc_pkg::*;
#(
  parameter int CYC_SHORT = RTC_CYC_SHORT_CLKS,
  parameter int CYC_LONG  = RTC_CYC_LONG_CLKS
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        osc_tick_i,
  input wire logic        conv_clk_o,
  input wire logic        meas_start_o,
  input wire logic        avg_done_o,
  input wire logic [4:0]  port_sel_o,
  input wire logic        ref_internal_o,
  input wire logic [4:0]  cap_ref_code_o
);
  // ----
  // Shadow lags by an edge, so compare only on a quiet bus
  // ----
  wire [7:0] idx   = adr_i[9:2];
  wire       bad   = (|adr_i[31:10]) || idx < RTC_IDX_TRIG
                     || idx > RTC_IDX_STAT;
  wire       req   = cyc_i && stb_i && !ack_o && !err_o;
  wire       wdone = cyc_i && ack_o && we_i && sel_i[0];
  wire       quiet = !cyc_i;
  logic [7:0]  pe_q, cr_q;
  logic [15:0] gap_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pe_q  <= 8'h0;
      cr_q  <= 8'h0;
      gap_q <= 16'hffff;
    end else begin
      if (wdone && idx == RTC_IDX_PORTS) pe_q <= dat_i[7:0];
      if (wdone && idx == RTC_IDX_CREF) cr_q <= dat_i[7:0];
      if (meas_start_o) gap_q <= 16'h1;
      else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  AST_ACK_TAKE: assert property (req && !bad |=> ack_o && !err_o)
    else $error("mapped access not acked");
  AST_ERR_TAKE: assert property (req && bad |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  AST_CONV_SRC: assert property (conv_clk_o |-> $past(osc_tick_i))
    else $error("divided clock without tick");
  AST_CONV_DIV1: assert property (
    quiet && $past(quiet) && cr_q[1:0] == 2'h0
    |-> conv_clk_o == $past(osc_tick_i)) else $error("divide by one off");
  AST_REF: assert property (
    quiet && $past(quiet) |-> ref_internal_o == pe_q[6])
    else $error("reference select mismatch");
  AST_PORTS: assert property (
    quiet && $past(quiet) |-> port_sel_o == pe_q[4:0])
    else $error("port selection mismatch");
  AST_CREF: assert property (
    quiet && $past(quiet) |-> cap_ref_code_o == cr_q[7:3])
    else $error("cap reference code mismatch");
  AST_GAP: assert property (meas_start_o |-> gap_q >= CYC_SHORT)
    else $error("measurement cycle too short");
  AST_GAP_LONG: assert property (
    meas_start_o && cr_q[2] |-> gap_q >= CYC_LONG)
    else $error("long measurement cycle too short");
  AST_AVG_PULSE: assert property (avg_done_o |=> !avg_done_o)
    else $error("average done held too long");
endmodule
bind rtc_conv_ctrl rtc_conv_ctrl_asserts #(
  .CYC_SHORT (CYC_SHORT),
  .CYC_LONG  (CYC_LONG)
) u_chk (.*);

// ===== test/rtc_src_model.sv
`timescale 1ns/1ps
// ----
// Trigger sources beside the converter
// ----
module rtc_src_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [1:0] which_i,
  output logic            osc_tick_o,
  output logic            pin_o,
  output logic            cap_o,
  output logic            run_end_o
);
  // Pin and run end are edge sensed, so one-cycle pulses do for all
  initial {run_end_o, cap_o, pin_o, osc_tick_o} = 4'h0;
  always @(posedge clk_i) begin
    {run_end_o, cap_o, pin_o, osc_tick_o} <= go_i ? 4'(1 << which_i) : 4'h0;
  end
endmodule

// ===== test/tb_rtc_conv_ctrl.sv
`timescale 1ns/1ps
module tb_rtc_conv_ctrl;
  import rtc_pkg::*;
  // ----
  // Bench
  // ----
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, go, e, ack_o, err_o;
  logic [31:0] adr_i, dat_i, dat_o;
  logic [3:0]  sel_i;
  logic [1:0]  which;
  logic [7:0]  q;
  logic [4:0]  port_sel_o, cap_ref_code_o;
  logic        osc_tick_i, pin_trig_i, cap_trig_i, cap_run_end_i;
  logic        conv_clk_o, meas_start_o, meas_keep_o, avg_done_o;
  logic        ref_internal_o;
  int          failures, compares, cycles, n_start, n_avg, n_conv, n_keep;
  logic [2:0]  src [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6};
  logic [7:0]  val [7] = '{8'h2d, 8'h5a, 8'hc3, 8'h96, 8'h40, 8'h75, 8'h7e};
  int          lens [4] = '{1, 4, 8, 16};
  // Short cycle lengths keep the run small
  localparam int CS = 8;
  localparam int CL = 16;
  rtc_conv_ctrl #(.CYC_SHORT(CS), .CYC_LONG(CL)) dut (.*);
  rtc_src_model u_src (
    .clk_i      (clk_i),
    .go_i       (go),
    .which_i    (which),
    .osc_tick_o (osc_tick_i),
    .pin_o      (pin_trig_i),
    .cap_o      (cap_trig_i),
    .run_end_o  (cap_run_end_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    n_start += meas_start_o;
    n_avg += avg_done_o;
    n_conv += conv_clk_o;
    n_keep += meas_keep_o;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix, d, input logic s);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'h3, w};
    sel_i <= s ? 4'hf : 4'he;
    adr_i <= {22'h0, ix, 2'h0};
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (!(ack_o === 1'b1 || err_o === 1'b1));
    q = dat_o[7:0];
    e = err_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] ix, d);
    bus(1'b1, ix, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] ix, ex);
    bus(1'b0, ix, 8'h0, 1'b1);
    chk({e, q}, {1'b0, ex}, "read");
  endtask
  task automatic zero();
    {n_start, n_avg, n_conv, n_keep} = '0;
  endtask
  task automatic fire(input logic [1:0] k, input int w);
    @(posedge clk_i);
    {go, which} <= {1'b1, k};
    @(posedge clk_i);
    go <= 1'b0;
    repeat (w) @(posedge clk_i);
  endtask
  initial begin
    {rst_i, cyc_i, stb_i, we_i, go, which, sel_i} = 11'h400;
    {adr_i, dat_i} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(8'(RTC_IDX_TRIG + i), 8'h0);
    for (int i = 0; i < 7; i++) wr(8'(RTC_IDX_TRIG + i), val[i]);
    for (int i = 0; i < 7; i++) rd(8'(RTC_IDX_TRIG + i), val[i]);
    chk(ref_internal_o, 1'b1, "ref");
    chk(cap_ref_code_o, 5'h0f, "cref");
    chk(port_sel_o, 5'h15, "ports");
    bus(1'b1, RTC_IDX_DIV_LO, 8'h0, 1'b0);
    rd(RTC_IDX_DIV_LO, 8'h5a);
    bus(1'b0, 8'h26, 8'h0, 1'b1);
    chk(e, 1'b1, "unmapped read");
    bus(1'b1, 8'h1c, 8'hff, 1'b1);
    chk(e, 1'b1, "unmapped write");
    rd(RTC_IDX_STAT, {4'h0, RTC_IDLE});
    for (int i = 1; i < 7; i++) wr(8'(RTC_IDX_TRIG + i), 8'h0);
    wr(RTC_IDX_PORTS, 8'h1f);
    for (int c = 0; c < 5; c++) begin
      wr(RTC_IDX_TRIG, {5'h0, src[c]});
      for (int k = 0; k < 4; k++) begin
        zero();
        fire(2'(k), 60);
        chk(n_avg, src[c] == src[k + 1], "source");
      end
    end
    // Alternate bank source takes over while selected
    wr(RTC_IDX_CTRL, 8'h01);
    wr(RTC_IDX_TRIG, 8'h28);
    rd(RTC_IDX_CTRL, 8'h01);
    zero();
    fire(2'h2, 60);
    chk(n_avg, 1, "alt bank");
    wr(RTC_IDX_CTRL, 8'h00);
    wr(RTC_IDX_TRIG, 8'h05);
    wr(RTC_IDX_PORTS, 8'h00);
    zero();
    fire(2'h2, 60);
    chk(n_start, 0, "no port");
    wr(RTC_IDX_PORTS, 8'h1f);
    // Six events: same pass count whatever the counter's leftover
    wr(RTC_IDX_TRIG, 8'h05);
    wr(RTC_IDX_DIV_LO, 8'h03);
    zero();
    repeat (6) fire(2'h2, 60);
    chk(n_avg, 2, "prediv");
    wr(RTC_IDX_TRIG, 8'h01);
    zero();
    repeat (6) fire(2'h0, 60);
    chk(n_avg, 2, "osc prediv");
    wr(RTC_IDX_TRIG, 8'h05);
    wr(RTC_IDX_DIV_LO, 8'h0);
    for (int a = 0; a < 4; a++) begin
      wr(RTC_IDX_DIV_HI, 8'(a << 6));
      wr(RTC_IDX_WARM, a[0] ? 8'h40 : 8'h00);
      wr(RTC_IDX_CREF, a[0] ? 8'h04 : 8'h00);
      zero();
      fire(2'h2, 600);
      chk(n_start, (a[0] ? 8 : 2) + lens[a], "count");
      chk(n_avg, 1, "avg");
      chk(n_keep, lens[a] * (a[0] ? CL : CS), "keep");
    end
    wr(RTC_IDX_TRIG, 8'h0);
    for (int d = 0; d < 4; d++) begin
      wr(RTC_IDX_CREF, 8'(d));
      zero();
      repeat (16) fire(2'h0, 3);
      chk(n_conv, 16 / (d == 0 ? 1 : 2 << d), "div");
    end
    close_out();
  end
endmodule
